// [pin_remap_cfg.svh]
/*
 Constants of the input remap fabric: widths, select codes, register
 offsets, reset values and the map of implemented remappable pins.
 Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef PIN_REMAP_CFG_SVH
`define PIN_REMAP_CFG_SVH

// sizes
`define NUM_DEST          22
`define NUM_VIRT          6
`define NUM_PIN           128
`define NUM_CMP           5
`define NUM_PERIPH_OUT    16
`define INSEL_REGS        6
`define VSEL_REGS         2

// input select codes
`define CODE_GROUND       8'h00
`define CODE_CMP_FIRST    8'h01
`define CODE_CMP_LAST     8'h04
`define CODE_CMP_FIVE     8'h0C
`define CODE_VIRT_FIRST   8'hB0
`define CODE_VIRT_LAST    8'hB5
`define CODE_FAULT_COMPARATOR_SOURCE_ONE   8'h01

// virtual output select: code k takes peripheral output k-1
`define VCODE_LAST        8'h10

// implemented remappable pin numbers, one bit each
`define PIN_IMPL_MASK     128'h33C00003_C0000160_B7FFFFFF_1B1F0000

// register byte offsets
`define OFS_INSEL_BASE    12'h000
`define OFS_VSEL0         12'h018
`define OFS_VSEL1         12'h01C
`define OFS_STATUS        12'h020

// reset values and write masks
`define RESET_SEL         32'h0000_0000
`define LOW_SLOTS_MASK    32'h0000_FFFF
`define STATUS_PAD        10'h000

`endif

// [pin_remap_fabric.sv]
/*
 Input side of the pin remap fabric: APB register file of per-input
 select fields, six virtual route outputs and the source muxes.
 Assumes pins and comparator outputs are asynchronous to clk_sys;
 peripheral outputs and analog flags come from clk_sys logic.
*/
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_remap_cfg.svh"

// Summary of operation
// - input and output route selects kept separate
// - each peripheral input owns its select field
// - 8-bit fields, four packed per register
// - code n routes implemented remappable pin n
// - code 0 low, 1-4 and 12 comparators
// - six virtual outputs from output remappers 176-181
// - codes 176-181 read the virtual outputs
// - fault-one code 1 takes comparator one
// - twenty-two selectable peripheral input destinations
// - remap claims pin, analog function still wins
module pin_remap_fabric
    import pin_remap_pkg::*;
(
    // clock, reset, enable
    input  wire logic   clk_sys,
    input  wire logic   reset,
    input  wire logic   ce,
    // register bus
    input  apb_req_type apb_req,
    output apb_rsp_type apb_rsp,
    // sources
    input  wire logic [127:0] remappable_pin,
    input  wire logic [127:0] pin_analog,
    input  wire logic [4:0]   comparator_outputs,
    input  wire logic [15:0]  periph_out,
    // routed results
    output periph_in_type     periph_in,
    output logic [5:0]        virtual_route_pins,
    output logic [127:0]      pin_claimed
);

    bus_state_type state;
    bus_state_type next_state;
    apb_rsp_type   next_rsp;
    logic [31:0]   input_select_regs [`INSEL_REGS];
    logic [31:0]   next_insel        [`INSEL_REGS];
    logic [31:0]   vsel              [`VSEL_REGS];
    logic [31:0]   next_vsel         [`VSEL_REGS];
    logic [127:0]  pin_meta;
    logic [127:0]  pin_sync;
    logic [4:0]    cmp_meta;
    logic [4:0]    cmp_sync;
    logic [127:0]  pin_eff;
    logic [7:0]    dest_code  [`NUM_DEST];
    logic [21:0]   dest_level;
    logic [21:0]   periph_vec;
    logic [21:0]   next_periph;
    logic [5:0]    next_vpins;
    logic [127:0]  next_claim;
    logic [7:0]    vcode;
    logic          access;
    logic          mapped;
    logic [31:0]   read_word;

    // two-stage synchronisers for asynchronous sources
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_meta <= '0;
            pin_sync <= '0;
            cmp_meta <= '0;
            cmp_sync <= '0;
        end else if (ce) begin
            pin_meta <= remappable_pin;
            pin_sync <= pin_meta;
            cmp_meta <= comparator_outputs;
            cmp_sync <= cmp_meta;
        end
    end

    // analog pins read low on the digital side
    assign pin_eff = pin_sync & ~pin_analog;

    // register bus
    assign access = apb_req.psel && apb_req.penable;
    assign mapped = (apb_req.paddr[1:0] == 2'h0)
                    && (apb_req.paddr <= `OFS_STATUS);

    always_comb begin
        read_word = '0;
        if (!mapped) begin
            read_word = '0;
        end else if (apb_req.paddr < `OFS_VSEL0) begin
            read_word = input_select_regs[apb_req.paddr[4:2]];
        end else if (apb_req.paddr == `OFS_VSEL0) begin
            read_word = vsel[0];
        end else if (apb_req.paddr == `OFS_VSEL1) begin
            read_word = vsel[1];
        end else begin
            read_word = {`STATUS_PAD, periph_vec};
        end
    end

    always_comb begin
        next_state = state;
        next_rsp   = apb_rsp;
        next_insel = input_select_regs;
        next_vsel  = vsel;
        unique case (state)
            BUS_IDLE: begin
                if (access) begin
                    next_state       = BUS_REPLY;
                    next_rsp.pready  = 1'b1;
                    next_rsp.pslverr = !mapped;
                    next_rsp.prdata  = read_word;
                end
            end
            BUS_REPLY: begin
                next_state      = BUS_IDLE;
                next_rsp.pready = 1'b0;
                if (access && apb_req.pwrite && mapped) begin
                    if (apb_req.paddr < `OFS_VSEL0) begin
                        next_insel[apb_req.paddr[4:2]] =
                            (apb_req.paddr[4:2] == 3'h5)
                            ? (apb_req.pwdata & `LOW_SLOTS_MASK)
                            : apb_req.pwdata;
                    end else if (apb_req.paddr == `OFS_VSEL0) begin
                        next_vsel[0] = apb_req.pwdata;
                    end else if (apb_req.paddr == `OFS_VSEL1) begin
                        next_vsel[1] = apb_req.pwdata & `LOW_SLOTS_MASK;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state   <= BUS_IDLE;
            apb_rsp <= '0;
            for (int i = 0; i < `INSEL_REGS; i++) begin
                input_select_regs[i] <= `RESET_SEL;
            end
            for (int i = 0; i < `VSEL_REGS; i++) begin
                vsel[i] <= `RESET_SEL;
            end
        end else if (ce) begin
            state             <= next_state;
            apb_rsp           <= next_rsp;
            input_select_regs <= next_insel;
            vsel              <= next_vsel;
        end
    end

    // one select field per destination
    always_comb begin
        for (int d = 0; d < `NUM_DEST; d++) begin
            dest_code[d] = field_of(input_select_regs[d / 4],
                                    2'(d % 4));
        end
    end

    for (genvar d = 0; d < `NUM_DEST; d++) begin : g_dest
        remap_source_select u_sel (
            .code       (dest_code[d]),
            .pin_level  (pin_eff),
            .cmp_level  (cmp_sync),
            .virt_level (virtual_route_pins),
            .level      (dest_level[d])
        );
    end

    // routing outputs
    always_comb begin
        next_periph = dest_level;
        next_claim  = '0;
        next_vpins  = '0;
        vcode       = '0;
        for (int d = 0; d < `NUM_DEST; d++) begin
            if (pin_code(dest_code[d])) begin
                next_claim[dest_code[d][6:0]] = 1'b1;
            end
        end
        for (int v = 0; v < `NUM_VIRT; v++) begin
            vcode = field_of(vsel[v / 4], 2'(v % 4));
            if (vcode != `CODE_GROUND && vcode <= `VCODE_LAST) begin
                next_vpins[v] = periph_out[4'(vcode - 8'h01)];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            periph_vec         <= '0;
            virtual_route_pins <= '0;
            pin_claimed        <= '0;
        end else if (ce) begin
            periph_vec         <= next_periph;
            virtual_route_pins <= next_vpins;
            pin_claimed        <= next_claim;
        end
    end

    assign periph_in = periph_in_type'(periph_vec);

    // checks on the first destination, fault one, first virtual pin and the bus reply
    logic [7:0] sel0;
    logic [7:0] sel_fault;
    logic [7:0] vsel0;
    logic       pin_pick0;
    logic       cmp_pick0;
    logic       cmp_first;
    logic       virt_pick0;
    logic       vout_pick0;
    logic       src_known0;
    logic [31:0] insel0;
    logic [31:0] wdata;

    assign sel0       = dest_code[0];
    assign sel_fault  = dest_code[8];
    assign vsel0      = field_of(vsel[0], 2'h0);
    assign pin_pick0  = pin_sync[sel0[6:0]];
    assign cmp_pick0  = cmp_sync[3'(sel0[2:0] - 3'h1)];
    assign cmp_first  = cmp_sync[0];
    assign virt_pick0 = virtual_route_pins[sel0[2:0]];
    assign vout_pick0 = periph_out[4'(vsel0 - 8'h01)];
    assign insel0     = input_select_regs[0];
    assign wdata      = apb_req.pwdata;
    assign src_known0 = sel0 == `CODE_GROUND || pin_code(sel0)
                        || sel0 == `CODE_CMP_FIVE
                        || (sel0 >= `CODE_CMP_FIRST
                            && sel0 <= `CODE_CMP_LAST)
                        || (sel0 >= `CODE_VIRT_FIRST
                            && sel0 <= `CODE_VIRT_LAST);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_ground_low;
        ce && sel0 == `CODE_GROUND |=> !periph_vec[0];
    endproperty
    a_ground_low: assert property (p_ground_low)
        else $error("ground code did not drive low");

    property p_pin_route;
        ce && pin_code(sel0) && !pin_analog[sel0[6:0]]
        |=> periph_vec[0] == $past(pin_pick0);
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("pin code did not route its pin");

    property p_analog_wins;
        ce && pin_code(sel0) && pin_analog[sel0[6:0]]
        |=> !periph_vec[0] && pin_claimed[$past(sel0[6:0])];
    endproperty
    a_analog_wins: assert property (p_analog_wins)
        else $error("analog pin leaked to remapped input");

    property p_cmp_route;
        ce && sel0 >= `CODE_CMP_FIRST && sel0 <= `CODE_CMP_LAST
        |=> periph_vec[0] == $past(cmp_pick0);
    endproperty
    a_cmp_route: assert property (p_cmp_route)
        else $error("comparator code routed wrong source");

    property p_fault_comparator_source_one;
        ce && sel_fault == `CODE_FAULT_COMPARATOR_SOURCE_ONE
        |=> periph_vec[8] == $past(cmp_first);
    endproperty
    a_fault_comparator_source_one: assert property (p_fault_comparator_source_one)
        else $error("fault one did not follow comparator one");

    property p_virtual_src;
        ce && sel0 >= `CODE_VIRT_FIRST && sel0 <= `CODE_VIRT_LAST
        |=> periph_vec[0] == $past(virt_pick0);
    endproperty
    a_virtual_src: assert property (p_virtual_src)
        else $error("virtual code routed wrong source");

    property p_unimpl_low;
        ce && !src_known0 |=> !periph_vec[0];
    endproperty
    a_unimpl_low: assert property (p_unimpl_low)
        else $error("unimplemented code not low");

    property p_vout_route;
        ce && vsel0 != `CODE_GROUND && vsel0 <= `VCODE_LAST
        |=> virtual_route_pins[0] == $past(vout_pick0);
    endproperty
    a_vout_route: assert property (p_vout_route)
        else $error("virtual output routed wrong source");

    property p_field_write;
        ce && state == BUS_REPLY && access && apb_req.pwrite
        && apb_req.paddr == `OFS_INSEL_BASE
        |=> insel0 == $past(wdata) ##1 periph_vec[0] == $past(dest_level[0]);
    endproperty
    a_field_write: assert property (p_field_write)
        else $error("select write not stored or not applied");

    property p_sets_apart;
        ce && state == BUS_REPLY && access && apb_req.pwrite
        && apb_req.paddr == `OFS_VSEL0
        |=> insel0 == $past(insel0);
    endproperty
    a_sets_apart: assert property (p_sets_apart)
        else $error("output select write touched input select");

    property p_reply_once;
        ce && state == BUS_IDLE && access
        |=> apb_rsp.pready ##1 (!apb_rsp.pready || !ce);
    endproperty
    a_reply_once: assert property (p_reply_once)
        else $error("bus reply not one cycle after access");

    c_pin_route: cover property (ce && pin_code(sel0) ##1 periph_vec[0]);
    c_virtual: cover property (ce && sel0 == `CODE_VIRT_FIRST
                               && virtual_route_pins[0]);
    c_slverr: cover property (apb_rsp.pready && apb_rsp.pslverr);

endmodule

// [pin_remap_fabric_tb.sv]
/* Self-checking bench of the input remap fabric over APB.
   Assumes pin_side_model drives all source levels. */
`timescale 1ns/1ps
`include "pin_remap_cfg.svh"

`define CHECK(what, exp, got) \
    begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end

module pin_remap_fabric_tb
    import pin_remap_pkg::*;
;
    logic          clk_sys;
    logic          reset;
    apb_req_type   apb_req;
    apb_rsp_type   apb_rsp;
    logic [127:0]  pin_set, analog_set, remappable_pin, pin_analog;
    logic [127:0]  pin_claimed;
    logic [4:0]    cmp_set, comparator_outputs;
    logic [15:0]   out_set, periph_out;
    periph_in_type periph_in;
    logic [5:0]    virtual_route_pins;
    logic [21:0]   dest_vec;
    logic [31:0]   rd;
    logic          err;
    logic          ce;
    int            mismatches, compares;
    localparam logic [7:0] pins [22] = '{8'h10, 8'h11, 8'h12, 8'h13,
        8'h14, 8'h18, 8'h19, 8'h1B, 8'h1C, 8'h20, 8'h23, 8'h30, 8'h3A,
        8'h3C, 8'h3D, 8'h3F, 8'h45, 8'h46, 8'h48, 8'h5E, 8'h61, 8'h7D};
    localparam logic [7:0] bad [8] = '{8'h05, 8'h0D, 8'h15, 8'h3B,
        8'h40, 8'h7F, 8'h80, 8'hFF};
    localparam logic [7:0] cmps [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0C};

    assign dest_vec = periph_in;

    pin_remap_fabric pin_remap_fabric_inst (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .ce                 (ce),
        .apb_req            (apb_req),
        .apb_rsp            (apb_rsp),
        .remappable_pin     (remappable_pin),
        .pin_analog         (pin_analog),
        .comparator_outputs (comparator_outputs),
        .periph_out         (periph_out),
        .periph_in          (periph_in),
        .virtual_route_pins (virtual_route_pins),
        .pin_claimed        (pin_claimed)
    );

    pin_side_model pin_side_model_inst (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .pin_set            (pin_set),
        .analog_set         (analog_set),
        .cmp_set            (cmp_set),
        .out_set            (out_set),
        .remappable_pin     (remappable_pin),
        .pin_analog         (pin_analog),
        .comparator_outputs (comparator_outputs),
        .periph_out         (periph_out)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one APB transfer; holds the request until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        apb_req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        `CHECK("pready", 1'b1, apb_rsp.pready)
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic eexp);
        apb(1'b0, a, 32'h0);
        `CHECK("prdata", exp, rd)
        `CHECK("pslverr", eexp, err)
    endtask

    // destination d sits in word d/4, slot d%4; sync path is 3 edges
    task automatic route(input int d, input logic [7:0] code,
                         input logic exp);
        apb(1'b1, 12'(4 * (d / 4)), 32'(code) << (8 * (d % 4)));
        repeat (5) @(posedge clk_sys);
        `CHECK("periph_in", exp, dest_vec[d])
    endtask

    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        apb_req = '0;
        pin_set = '0;
        analog_set = '0;
        cmp_set = '0;
        out_set = '0;
        mismatches = 0;
        compares = 0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 0; a <= 32; a += 4)
            rd_chk(12'(a), 32'h0, 1'b0);
        `CHECK("reset route", 22'h0, dest_vec)
        `CHECK("reset claim", 128'h0, pin_claimed)
        $display("test reset done");
        apb(1'b1, `OFS_INSEL_BASE, 32'hA55A3C10);
        rd_chk(`OFS_INSEL_BASE, 32'hA55A3C10, 1'b0);
        apb(1'b1, 12'h014, 32'hFFFFFFFF);
        rd_chk(12'h014, `LOW_SLOTS_MASK, 1'b0);
        apb(1'b1, `OFS_VSEL1, 32'hFFFFFFFF);
        rd_chk(`OFS_VSEL1, `LOW_SLOTS_MASK, 1'b0);
        apb(1'b1, 12'h024, 32'h1);
        rd_chk(12'h024, 32'h0, 1'b1);
        rd_chk(12'h002, 32'h0, 1'b1);
        apb(1'b1, `OFS_INSEL_BASE, 32'h0);
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b1, `OFS_VSEL1, 32'h0);
        apb(1'b1, `OFS_STATUS, 32'hFFFFFFFF);
        rd_chk(`OFS_STATUS, 32'h0, 1'b0);
        $display("test registers done");
        pin_set <= '1;
        for (int d = 0; d < 22; d++)
            route(d, pins[d], 1'b1);
        `CHECK("claim", 1'b1, pin_claimed[125])
        analog_set[125] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHECK("analog pin", 1'b0, dest_vec[21])
        route(0, 8'h7D, 1'b0);
        for (int i = 0; i < 8; i++)
            route(0, bad[i], 1'b0);
        $display("test pins done");
        pin_set <= '0;
        for (int i = 0; i < 5; i++) begin
            cmp_set <= 5'(1 << i);
            route(0, cmps[i], 1'b1);
        end
        cmp_set <= 5'h1F;
        route(0, `CODE_GROUND, 1'b0);
        cmp_set <= 5'h1E;
        route(8, `CODE_FAULT_COMPARATOR_SOURCE_ONE, 1'b0);
        cmp_set <= 5'h01;
        repeat (5) @(posedge clk_sys);
        `CHECK("fault one", 1'b1, dest_vec[8])
        $display("test comparators done");
        out_set <= 16'h8001;
        apb(1'b1, `OFS_VSEL0, 32'h11021001);
        apb(1'b1, `OFS_VSEL1, 32'h00001001);
        repeat (3) @(posedge clk_sys);
        `CHECK("virtual", 6'h33, virtual_route_pins)
        for (int k = 0; k < 6; k++)
            route(0, 8'hB0 + 8'(k), 1'(6'h33 >> k));
        apb(1'b1, 12'h008, 32'h00B0B200);
        repeat (5) @(posedge clk_sys);
        `CHECK("dest nine", 1'b0, dest_vec[9])
        `CHECK("dest ten", 1'b1, dest_vec[10])
        ce <= 1'b0;
        out_set <= 16'h0;
        repeat (3) @(posedge clk_sys);
        `CHECK("frozen", 6'h33, virtual_route_pins)
        ce <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHECK("resumed", 6'h0, virtual_route_pins)
        $display("test virtual done");
        finish_test();
    end
endmodule

// [pin_remap_pkg.sv]
/*
 Types shared by the input remap fabric: bus carriers, routed input
 bundle, bus state and select-field helpers.
 Assumes pin_remap_cfg.svh is on the include path.
*/
`include "pin_remap_cfg.svh"

package pin_remap_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    // bit 0 is the first external interrupt
    typedef struct packed {
        logic sent_two_in;
        logic sent_one_in;
        logic deadtime_comp_three_in;
        logic deadtime_comp_two_in;
        logic deadtime_comp_one_in;
        logic pwm_sync_one_in;
        logic can_one_receive_in;
        logic spi_two_select_in;
        logic spi_two_clock_in;
        logic spi_two_data_in;
        logic uart_two_receive_in;
        logic uart_one_receive_in;
        logic pwm_fault_two_in;
        logic pwm_fault_one_in;
        logic compare_fault_a_in;
        logic capture_four_in;
        logic capture_three_in;
        logic capture_two_in;
        logic capture_one_in;
        logic timer_two_clock_in;
        logic ext_irq_two_in;
        logic ext_irq_one_in;
    } periph_in_type;

    typedef enum logic [0:0] {
        BUS_IDLE  = 1'b0,
        BUS_REPLY = 1'b1
    } bus_state_type;

    function automatic logic [7:0] field_of(input logic [31:0] word,
                                            input logic [1:0]  slot);
        field_of = word[slot*8 +: 8];
    endfunction

    function automatic logic pin_code(input logic [7:0] code);
        logic [127:0] mask;
        mask     = `PIN_IMPL_MASK;
        pin_code = !code[7] && mask[code[6:0]];
    endfunction

endpackage

// [pin_side_model.sv]
/* Far-side model: pins, analog modes, comparator and peripheral outputs,
   each driven one clk_sys edge after the bench asks.
   Assumes one clock domain and the bench's reset. */
`timescale 1ns/1ps

module pin_side_model (
    // clock, reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    // requested levels
    input  wire logic [127:0] pin_set,
    input  wire logic [127:0] analog_set,
    input  wire logic [4:0]   cmp_set,
    input  wire logic [15:0]  out_set,
    // driven levels
    output logic [127:0]      remappable_pin,
    output logic [127:0]      pin_analog,
    output logic [4:0]        comparator_outputs,
    output logic [15:0]       periph_out
);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            remappable_pin     <= '0;
            pin_analog         <= '0;
            comparator_outputs <= '0;
            periph_out         <= '0;
        end else begin
            remappable_pin     <= pin_set;
            pin_analog         <= analog_set;
            comparator_outputs <= cmp_set;
            periph_out         <= out_set;
        end
    end
endmodule

// [remap_source_select.sv]
/*
 One input remapper: picks the source of a peripheral input from its
 8-bit select code. Purely combinational.
 Assumes pin levels are already synchronised and analog-gated.
*/
`timescale 1ns/1ps
`include "pin_remap_cfg.svh"

module remap_source_select
    import pin_remap_pkg::*;
(
    // select
    input  wire logic [7:0]   code,
    // sources
    input  wire logic [127:0] pin_level,
    input  wire logic [4:0]   cmp_level,
    input  wire logic [5:0]   virt_level,
    // result
    output logic              level
);

    always_comb begin
        level = 1'b0;
        if (code >= `CODE_CMP_FIRST && code <= `CODE_CMP_LAST) begin
            level = cmp_level[3'(code[2:0] - 3'h1)];
        end else if (code == `CODE_CMP_FIVE) begin
            level = cmp_level[4];
        end else if (code >= `CODE_VIRT_FIRST
                     && code <= `CODE_VIRT_LAST) begin
            level = virt_level[code[2:0]];
        end else if (pin_code(code)) begin
            level = pin_level[code[6:0]];
        end
    end

endmodule
